// ---- src/ips_pkg.sv ----
// Constants for the input polarity and multispeed select block
package ips_pkg;
    localparam int unsigned IPS_CLK_HZ = 100_000_000;
    // Settle time unit is one millisecond
    localparam int unsigned IPS_SETTLE_UNIT_US = 1000;
    localparam int unsigned IPS_SETTLE_TICK_CYCLES = IPS_SETTLE_UNIT_US * (IPS_CLK_HZ / 1_000_000);

    localparam int unsigned IPS_NUM_TERM = 8;
    localparam int unsigned IPS_FREQ_W = 16;

    // Register byte offsets
    localparam logic [7:0] IPS_ADDR_CTRL = 8'h00;
    localparam logic [7:0] IPS_ADDR_POLARITY = 8'h04;
    localparam logic [7:0] IPS_ADDR_FUNC_LO = 8'h08;
    localparam logic [7:0] IPS_ADDR_FUNC_HI = 8'h0c;
    localparam logic [7:0] IPS_ADDR_SETTLE = 8'h10;
    localparam logic [7:0] IPS_ADDR_SPEED_ZERO = 8'h14;
    localparam logic [7:0] IPS_ADDR_STATUS = 8'h18;
    localparam logic [7:0] IPS_ADDR_START_FREQ = 8'h1c;
    localparam logic [7:0] IPS_ADDR_MAX_FREQ = 8'h20;
    localparam logic [7:0] IPS_ADDR_TABLE_BASE = 8'h40;
    localparam logic [7:0] IPS_ADDR_TABLE_LAST = 8'h78;

    // Control register fields
    localparam int unsigned IPS_CTRL_MODE_LSB = 0;
    localparam int unsigned IPS_CTRL_SRC_BIT = 2;
    localparam int unsigned IPS_CTRL_REV_BIT = 3;
    localparam int unsigned IPS_CTRL_FWDPOL_LSB = 4;

    // Polarity codes
    localparam logic [1:0] IPS_POL_NO = 2'h0;
    localparam logic [1:0] IPS_POL_NC = 2'h1;

    // Speed select modes
    localparam logic [1:0] IPS_MODE_BINARY = 2'h0;
    localparam logic [1:0] IPS_MODE_ONEHOT = 2'h1;

    // Terminal function codes (decimal codes written in hex)
    localparam logic [7:0] IPS_FN_BINARY_BIT0 = 8'h02;
    localparam logic [7:0] IPS_FN_FAULT_CLEAR = 8'h12;
    localparam logic [7:0] IPS_FN_ONEHOT_IN1 = 8'h20;

    // Reset values
    localparam logic [31:0] IPS_RST_CTRL = 32'h0000_0000;
    localparam logic [15:0] IPS_RST_POLARITY = 16'h0000;
    localparam logic [31:0] IPS_RST_FUNC = 32'h0000_0000;
    localparam logic [15:0] IPS_RST_SETTLE = 16'h0000;
    localparam logic [15:0] IPS_RST_FREQ = 16'h0000;
    localparam logic [15:0] IPS_RST_MAX_FREQ = 16'hffff;
endpackage : ips_pkg

// ---- src/ips_input_speed_select.sv ----
// Input polarity conditioning and multispeed select with Wishbone registers
// Operation
// - Per-terminal polarity: 00 normally-open, 01 normally-closed
// - Normally-open: closed contact means asserted
// - Normally-closed: open contact means asserted
// - Forward-run terminal has its own polarity
// - Fault-clear terminal always sensed normally-open
// - Mode 00 binary sixteen speeds, 01 single-bit
// - Binary uses four inputs, single-bit seven
// - Binary index from bits, input1 LSB
// - Binary inputs bound by function codes 02-05
// - Binary indexes 1-15 use preset table
// - Index 0: stored value or analog inputs
// - Binary mode waits programmable settle time
// - Index updates only after stable settle period
// - Single-bit inputs bound by codes 32-38
// - Single input n selects preset entry n
// - Lowest-numbered asserted single-bit input wins
// - Index 0 only when all seven deasserted
// - Negative analog sum reverses commanded direction
// - Preset entries accept zero or start..max
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module ips_input_speed_select #(
    parameter int unsigned SETTLE_TICK_CYCLES = ips_pkg::IPS_SETTLE_TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic reset,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Terminal contacts, high while closed
    input wire logic [ips_pkg::IPS_NUM_TERM-1:0] terminalContactIn,
    input wire logic forwardRunContactIn,
    // Signed analog main and auxiliary frequency references
    input wire logic signed [ips_pkg::IPS_FREQ_W-1:0] analogMainFreq,
    input wire logic signed [ips_pkg::IPS_FREQ_W-1:0] analogAuxFreq,
    // Conditioned outputs
    output logic [ips_pkg::IPS_NUM_TERM-1:0] terminalActive,
    output logic forwardRunActive,
    output logic faultClearActive,
    output logic [3:0] speedIndex,
    output logic [ips_pkg::IPS_FREQ_W-1:0] outputFrequencySetpoint,
    output logic directionReverse
);
    import ips_pkg::*;

    localparam int unsigned TICK_W = $clog2(SETTLE_TICK_CYCLES + 1);

    // Register state
    logic [31:0] ctrl_q;
    logic [15:0] terminalPolarityCfg_q;
    logic [31:0] funcLo_q;
    logic [31:0] funcHi_q;
    logic [15:0] inputSettleTime_q;
    logic [15:0] speedZeroFrequency_q;
    logic [15:0] startFreq_q;
    logic [15:0] maxFreq_q;
    logic [15:0] presetFrequencyTable_q [1:15];

    // Conditioning state
    logic [IPS_NUM_TERM-1:0] termSync1_q;
    logic [IPS_NUM_TERM-1:0] termSync2_q;
    logic fwdSync1_q;
    logic fwdSync2_q;
    logic [IPS_NUM_TERM-1:0] termActive_d;
    logic [IPS_NUM_TERM-1:0] termActive_q;
    logic fwdActive_q;

    // Decode state
    logic [3:0] binaryRaw;
    logic [6:0] onehotRaw;
    logic [3:0] onehotIndex;
    logic [3:0] candidate_q;
    logic [15:0] stableMs_q;
    logic [TICK_W-1:0] tickCnt_q;
    logic [3:0] speedIndex_q;

    logic [1:0] speedSelectMode;
    logic srcTerminal;
    logic analogReversible;
    logic [1:0] forwardInputPolarityCfg;
    logic [7:0] termFunc [0:IPS_NUM_TERM-1];

    logic busReq;
    logic busWrite;
    logic [31:0] writeMerged;
    logic [31:0] readMux;
    logic [3:0] tableIdx;
    logic tableHit;
    logic signed [IPS_FREQ_W:0] analogSum;
    logic [IPS_FREQ_W:0] analogMag;
    logic settleTick;
    logic tableValueOk;
    logic [31:0] statusWord;

    assign speedSelectMode = ctrl_q[IPS_CTRL_MODE_LSB +: 2];
    assign srcTerminal = ctrl_q[IPS_CTRL_SRC_BIT];
    assign analogReversible = ctrl_q[IPS_CTRL_REV_BIT];
    assign forwardInputPolarityCfg = ctrl_q[IPS_CTRL_FWDPOL_LSB +: 2];

    // Function code per terminal, terminal one in the low byte
    generate
        for (genvar t = 0; t < 4; t++) begin : g_func
            assign termFunc[t] = funcLo_q[8*t +: 8];
            assign termFunc[t+4] = funcHi_q[8*t +: 8];
        end
    endgenerate

    // Bus strobe qualifiers; ack drops the cycle after it was given
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWrite = busReq && wb_we_i;
    assign tableHit = (wb_adr_i >= IPS_ADDR_TABLE_BASE) && (wb_adr_i <= IPS_ADDR_TABLE_LAST)
        && (wb_adr_i[1:0] == 2'h0);
    assign tableIdx = 4'((wb_adr_i - IPS_ADDR_TABLE_BASE) >> 2) + 4'h1;

    // Byte-lane merge of write data over the addressed register
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            writeMerged[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : readMux[8*b +: 8];
        end
    end

    // Status word: index, conditioned terminals, forward, fault clear, reverse
    assign statusWord = {13'h0, directionReverse, faultClearActive, fwdActive_q, termActive_q,
        4'h0, speedIndex_q};

    // Read mux; unmapped addresses read zero
    always_comb begin
        readMux = 32'h0000_0000;
        if (tableHit) begin
            readMux = {16'h0000, presetFrequencyTable_q[tableIdx]};
        end else begin
            unique case (wb_adr_i)
                IPS_ADDR_CTRL: readMux = {26'h0, ctrl_q[5:0]};
                IPS_ADDR_POLARITY: readMux = {16'h0000, terminalPolarityCfg_q};
                IPS_ADDR_FUNC_LO: readMux = funcLo_q;
                IPS_ADDR_FUNC_HI: readMux = funcHi_q;
                IPS_ADDR_SETTLE: readMux = {16'h0000, inputSettleTime_q};
                IPS_ADDR_SPEED_ZERO: readMux = {16'h0000, speedZeroFrequency_q};
                IPS_ADDR_START_FREQ: readMux = {16'h0000, startFreq_q};
                IPS_ADDR_MAX_FREQ: readMux = {16'h0000, maxFreq_q};
                IPS_ADDR_STATUS: readMux = statusWord;
                default: readMux = 32'h0000_0000;
            endcase
        end
    end

    // Ack, one cycle after the request; busReq holds off a second ack
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    // Read data is captured with the ack and holds until the next read
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busReq && !wb_we_i) begin
            wb_dat_o <= readMux;
        end
    end

    // Configuration registers written by software
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= IPS_RST_CTRL;
            terminalPolarityCfg_q <= IPS_RST_POLARITY;
            funcLo_q <= IPS_RST_FUNC;
            funcHi_q <= IPS_RST_FUNC;
            inputSettleTime_q <= IPS_RST_SETTLE;
            speedZeroFrequency_q <= IPS_RST_FREQ;
            startFreq_q <= IPS_RST_FREQ;
            maxFreq_q <= IPS_RST_MAX_FREQ;
        end else if (busWrite && !tableHit) begin
            unique case (wb_adr_i)
                IPS_ADDR_CTRL: ctrl_q <= {26'h0, writeMerged[5:0]};
                IPS_ADDR_POLARITY: terminalPolarityCfg_q <= writeMerged[15:0];
                IPS_ADDR_FUNC_LO: funcLo_q <= writeMerged;
                IPS_ADDR_FUNC_HI: funcHi_q <= writeMerged;
                IPS_ADDR_SETTLE: inputSettleTime_q <= writeMerged[15:0];
                IPS_ADDR_SPEED_ZERO: speedZeroFrequency_q <= writeMerged[15:0];
                IPS_ADDR_START_FREQ: startFreq_q <= writeMerged[15:0];
                IPS_ADDR_MAX_FREQ: maxFreq_q <= writeMerged[15:0];
                default: ;
            endcase
        end
    end

    // Zero parks an entry; anything else must lie inside start..max
    assign tableValueOk = (writeMerged[15:0] == 16'h0000) ||
        (writeMerged[15:0] >= startFreq_q && writeMerged[15:0] <= maxFreq_q);

    // Preset table; out-of-range values are dropped so the old entry stays
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            for (int i = 1; i <= 15; i++) begin
                presetFrequencyTable_q[i] <= IPS_RST_FREQ;
            end
        end else if (busWrite && tableHit) begin
            if (tableValueOk) begin
                presetFrequencyTable_q[tableIdx] <= writeMerged[15:0];
            end
        end
    end

    // Two-flop synchronisers on the terminal contacts
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            termSync1_q <= '0;
            termSync2_q <= '0;
        end else begin
            termSync1_q <= terminalContactIn;
            termSync2_q <= termSync1_q;
        end
    end

    // Same two-flop path for the forward-run contact
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fwdSync1_q <= 1'b0;
            fwdSync2_q <= 1'b0;
        end else begin
            fwdSync1_q <= forwardRunContactIn;
            fwdSync2_q <= fwdSync1_q;
        end
    end

    // Polarity; fault-clear terminals ignore the NC setting
    always_comb begin
        for (int t = 0; t < IPS_NUM_TERM; t++) begin
            if (terminalPolarityCfg_q[2*t +: 2] == IPS_POL_NC &&
                termFunc[t] != IPS_FN_FAULT_CLEAR) begin
                termActive_d[t] = !termSync2_q[t];
            end else begin
                termActive_d[t] = termSync2_q[t];
            end
        end
    end

    // Conditioned levels, the only source for all decoding
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            termActive_q <= '0;
        end else begin
            termActive_q <= termActive_d;
        end
    end

    // Forward-run level after its own polarity setting
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fwdActive_q <= 1'b0;
        end else begin
            fwdActive_q <= (forwardInputPolarityCfg == IPS_POL_NC) ? !fwdSync2_q
                : fwdSync2_q;
        end
    end

    // Gather speed inputs from whichever terminals carry the codes
    always_comb begin
        binaryRaw = 4'h0;
        onehotRaw = 7'h00;
        for (int t = 0; t < IPS_NUM_TERM; t++) begin
            for (int b = 0; b < 4; b++) begin
                if (termFunc[t] == IPS_FN_BINARY_BIT0 + 8'(b) && termActive_q[t]) begin
                    binaryRaw[b] = 1'b1;
                end
            end
            for (int s = 0; s < 7; s++) begin
                if (termFunc[t] == IPS_FN_ONEHOT_IN1 + 8'(s) && termActive_q[t]) begin
                    onehotRaw[s] = 1'b1;
                end
            end
        end
    end

    // Fault clear is raised by any active terminal that carries its code
    always_comb begin
        faultClearActive = 1'b0;
        for (int t = 0; t < IPS_NUM_TERM; t++) begin
            if (termFunc[t] == IPS_FN_FAULT_CLEAR && termActive_q[t]) begin
                faultClearActive = 1'b1;
            end
        end
    end

    // Priority encode: the lowest asserted input wins, none gives zero
    always_comb begin
        onehotIndex = 4'h0;
        for (int s = 6; s >= 0; s--) begin
            if (onehotRaw[s]) begin
                onehotIndex = 4'(s + 1);
            end
        end
    end

    // One-cycle tick at the end of each settle unit
    assign settleTick = (tickCnt_q == TICK_W'(SETTLE_TICK_CYCLES - 1));

    // Millisecond prescaler for the settle timer
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            tickCnt_q <= '0;
        end else if (settleTick) begin
            tickCnt_q <= '0;
        end else begin
            tickCnt_q <= tickCnt_q + TICK_W'(1);
        end
    end

    // Settle filter; a long settle time slows the binary speed index response
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            candidate_q <= 4'h0;
            stableMs_q <= 16'h0000;
            speedIndex_q <= 4'h0;
        end else if (speedSelectMode == IPS_MODE_ONEHOT) begin
            candidate_q <= onehotIndex;
            stableMs_q <= 16'h0000;
            speedIndex_q <= onehotIndex;
        end else if (binaryRaw != candidate_q) begin
            candidate_q <= binaryRaw;
            stableMs_q <= 16'h0000;
        end else if (stableMs_q >= inputSettleTime_q) begin
            speedIndex_q <= candidate_q;
        end else if (settleTick) begin
            stableMs_q <= stableMs_q + 16'h0001;
        end
    end

    // Signed sum of the analog references and its magnitude
    assign analogSum = (IPS_FREQ_W+1)'(analogMainFreq) + (IPS_FREQ_W+1)'(analogAuxFreq);
    assign analogMag = analogSum[IPS_FREQ_W] ? (IPS_FREQ_W+1)'(-analogSum)
        : (IPS_FREQ_W+1)'(analogSum);

    // Direction follows the sign of the sum when the source and reversible bits are set, whatever the index
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            directionReverse <= 1'b0;
        end else begin
            directionReverse <= srcTerminal && analogReversible
                && analogSum[IPS_FREQ_W];
        end
    end

    // Frequency setpoint from the table, the speed-zero value or the analog sum
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            outputFrequencySetpoint <= 16'h0000;
        end else begin
            if (speedIndex_q != 4'h0) begin
                outputFrequencySetpoint <= presetFrequencyTable_q[speedIndex_q];
            end else if (!srcTerminal) begin
                outputFrequencySetpoint <= speedZeroFrequency_q;
            end else if (analogMag[IPS_FREQ_W]) begin
                outputFrequencySetpoint <= 16'hffff;
            end else begin
                outputFrequencySetpoint <= analogMag[IPS_FREQ_W-1:0];
            end
        end
    end

    // Binary index already packs input 1 as bit 0
    assign speedIndex = speedIndex_q;
    assign terminalActive = termActive_q;
    assign forwardRunActive = fwdActive_q;
endmodule : ips_input_speed_select

// ---- tb/ips_contact_model.sv ----
// Behavioural model of the switch contacts wired to the terminals
`timescale 1ns/1ps
module ips_contact_model (
    input wire logic mclk,
    input wire logic [7:0] closeCmd,
    input wire logic fwdCmd,
    input wire logic bounceEn,
    output logic [7:0] contactOut = 8'h00,
    output logic fwdOut = 1'b0
);
    // Contacts follow the command; a bouncing switch flips every cycle
    always @(posedge mclk) begin
        contactOut <= (bounceEn && contactOut === closeCmd) ? ~closeCmd : closeCmd;
        fwdOut <= fwdCmd;
    end
endmodule : ips_contact_model

// ---- tb/ips_select_props.sv ----
// Port-level checks for the input polarity and multispeed select block
`timescale 1ns/1ps
module ips_select_props #(
    parameter int unsigned SETTLE_TICK_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [ips_pkg::IPS_NUM_TERM-1:0] terminalContactIn,
    input wire logic forwardRunContactIn,
    input wire logic signed [ips_pkg::IPS_FREQ_W-1:0] analogMainFreq,
    input wire logic signed [ips_pkg::IPS_FREQ_W-1:0] analogAuxFreq,
    input wire logic [ips_pkg::IPS_NUM_TERM-1:0] terminalActive,
    input wire logic forwardRunActive,
    input wire logic faultClearActive,
    input wire logic [3:0] speedIndex,
    input wire logic directionReverse
);
    import ips_pkg::*;
    logic signed [16:0] sumNow;
    logic [7:0] prevTerm_q;
    logic prevFwd_q;
    logic [3:0] quiet_q;
    // Signed sum of both references, one bit wider so it cannot wrap
    assign sumNow = 17'(analogMainFreq) + 17'(analogAuxFreq);
    // Cycles since a contact moved or a register was written
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prevTerm_q <= '0;
            prevFwd_q <= 1'b0;
            quiet_q <= '0;
        end else begin
            prevTerm_q <= terminalContactIn;
            prevFwd_q <= forwardRunContactIn;
            if (terminalContactIn != prevTerm_q || forwardRunContactIn != prevFwd_q
                    || (wb_ack_o && wb_we_i)) begin
                quiet_q <= '0;
            end else if (quiet_q != 4'hf) begin
                quiet_q <= quiet_q + 4'h1;
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    read_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
    status_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == IPS_ADDR_STATUS
        |-> wb_dat_o[18:8] == {$past(directionReverse), $past(faultClearActive),
        $past(forwardRunActive), $past(terminalActive)} && wb_dat_o[3:0] == $past(speedIndex))
        else $error("status word wrong");
    unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h30
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    reverse_sign_a: assert property (directionReverse |-> $past(sumNow) < 0)
        else $error("reverse without negative sum");
    fault_clear_a: assert property (faultClearActive |-> terminalActive != '0)
        else $error("fault clear without active terminal");
    quiet_inputs_a: assert property (quiet_q >= 4'h4
        |-> $stable(terminalActive) && $stable(forwardRunActive))
        else $error("conditioned input moved while contacts idle");
    cover property (wb_ack_o && wb_adr_i == IPS_ADDR_STATUS);
    cover property (directionReverse);
    cover property (faultClearActive);
    cover property (speedIndex == 4'hf);
endmodule : ips_select_props

bind ips_input_speed_select ips_select_props #(.SETTLE_TICK_CYCLES(SETTLE_TICK_CYCLES))
    ips_select_props_i (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
    .wb_ack_o, .terminalContactIn, .forwardRunContactIn, .analogMainFreq, .analogAuxFreq,
    .terminalActive, .forwardRunActive, .faultClearActive, .speedIndex, .directionReverse);

// ---- tb/input_polarity_multispeed_select_tb.sv ----
// Self-checking bench for the input polarity and multispeed select block
`timescale 1ns/1ps
module input_polarity_multispeed_select_tb;
    import ips_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd, expv;
    logic [7:0] closeCmd = '0, terminalContactIn, terminalActive, pat, nc;
    logic fwdCmd = 1'b0, bounceEn = 1'b0, forwardRunContactIn, forwardRunActive;
    logic faultClearActive, directionReverse;
    logic signed [15:0] analogMainFreq = '0, analogAuxFreq = '0;
    logic [3:0] speedIndex;
    logic [15:0] outputFrequencySetpoint, pol;
    logic [15:0] trials [4] = '{16'h2000, 16'h000f, 16'h0000, 16'h1000};
    logic [15:0] presetTbl [$];
    int errCount = 0, compares = 0, seed = 40;
    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;
    ips_contact_model ips_contact_model_i (.mclk, .closeCmd, .fwdCmd, .bounceEn,
        .contactOut(terminalContactIn), .fwdOut(forwardRunContactIn));
    ips_input_speed_select #(.SETTLE_TICK_CYCLES(4)) ips_input_speed_select_i (.mclk, .reset,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .terminalContactIn, .forwardRunContactIn, .analogMainFreq, .analogAuxFreq,
        .terminalActive, .forwardRunActive, .faultClearActive, .speedIndex,
        .outputFrequencySetpoint, .directionReverse);
    task automatic checkVal(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : checkVal
    // One classic cycle; waits for ack however long it takes
    task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do @(posedge mclk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask : wbCycle
    task automatic waitCyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : waitCyc
    task automatic checkSpeed(input int idx);
        checkVal("speedIndex", speedIndex, 32'(idx));
        checkVal("setpoint", outputFrequencySetpoint, presetTbl[idx]);
    endtask : checkSpeed
    // Priority model: lowest asserted single-bit input wins
    function automatic int ohIdx(input logic [6:0] p);
        for (int i = 0; i < 7; i++) if (p[i]) return i + 1;
        return 0;
    endfunction : ohIdx
    task automatic results();
        if (errCount == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    // Hang guard, far beyond the expected run length
    initial begin
        #200000;
        errCount++;
        results();
    end
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        wbCycle(0, IPS_ADDR_MAX_FREQ, 0);
        checkVal("maxFreq", rd, 32'(IPS_RST_MAX_FREQ));
        wbCycle(1, 8'h30, 32'hffff_ffff);
        wbCycle(0, 8'h30, 0);
        checkVal("unmapped", rd, 0);
        for (int k = 0; k < 4; k++) begin
            pol = 16'($random(seed)) & 16'h5555;
            pat = 8'($random(seed));
            wbCycle(1, IPS_ADDR_POLARITY, {16'h0, pol});
            closeCmd <= pat;
            waitCyc(6);
            for (int t = 0; t < 8; t++) nc[t] = pol[2 * t];
            checkVal("terminalActive", terminalActive, pat ^ nc);
        end
        for (int k = 0; k < 4; k++) begin
            wbCycle(1, IPS_ADDR_CTRL, 32'(k[1]) << IPS_CTRL_FWDPOL_LSB);
            fwdCmd <= k[0];
            waitCyc(6);
            checkVal("forwardRunActive", forwardRunActive, k[0] ^ k[1]);
        end
        // Fault clear on an inverted terminal still senses as closed-active
        wbCycle(1, IPS_ADDR_POLARITY, 32'h1);
        wbCycle(1, IPS_ADDR_FUNC_LO, 32'(IPS_FN_FAULT_CLEAR));
        for (int b = 0; b < 2; b++) begin
            closeCmd <= 8'(b);
            waitCyc(6);
            checkVal("faultClearActive", faultClearActive, b[0]);
        end
        wbCycle(1, IPS_ADDR_POLARITY, 0);
        wbCycle(1, IPS_ADDR_FUNC_LO, 32'h0504_0302);
        wbCycle(1, IPS_ADDR_FUNC_HI, 0);
        wbCycle(1, IPS_ADDR_SPEED_ZERO, 32'h77);
        presetTbl.push_back(16'h77);
        for (int n = 1; n < 16; n++) begin
            presetTbl.push_back(16'h0100 + 16'(n));
            wbCycle(1, IPS_ADDR_TABLE_BASE + 8'(4 * (n - 1)), 32'(presetTbl[n]));
        end
        for (int n = 0; n < 16; n++) begin
            closeCmd <= {4'($random(seed)), 4'(n)};
            waitCyc(10);
            checkSpeed(n);
        end
        // Chattering inputs must never reach the index
        wbCycle(1, IPS_ADDR_SETTLE, 32'h2);
        closeCmd <= 8'h05;
        bounceEn <= 1'b1;
        waitCyc(40);
        checkVal("speedIndex", speedIndex, 4'hf);
        bounceEn <= 1'b0;
        waitCyc(7);
        checkVal("speedIndex", speedIndex, 4'hf);
        waitCyc(16);
        checkSpeed(5);
        wbCycle(1, IPS_ADDR_FUNC_LO, 32'h2322_2120);
        wbCycle(1, IPS_ADDR_FUNC_HI, 32'h0026_2524);
        wbCycle(1, IPS_ADDR_CTRL, 32'h1);
        for (int k = 0; k < 10; k++) begin
            pat = (k < 7) ? 8'(1 << k) : (k == 9) ? 8'h80 : 8'($random(seed));
            closeCmd <= pat;
            waitCyc(8);
            checkSpeed(ohIdx(pat[6:0]));
        end
        wbCycle(1, IPS_ADDR_CTRL, 32'h0c);
        closeCmd <= 8'h00;
        for (int k = 0; k < 2; k++) begin
            analogMainFreq <= k ? 16'sd300 : -16'sd300;
            analogAuxFreq <= 16'sd100;
            waitCyc(24);
            checkVal("setpoint", outputFrequencySetpoint, k ? 32'd400 : 32'd200);
            checkVal("directionReverse", directionReverse, !k);
        end
        wbCycle(0, IPS_ADDR_STATUS, 0);
        checkVal("statusIndex", rd[3:0], 4'h0);
        wbCycle(1, IPS_ADDR_START_FREQ, 32'h10);
        wbCycle(1, IPS_ADDR_MAX_FREQ, 32'h1000);
        expv = 32'h0101;
        for (int k = 0; k < 4; k++) begin
            if (trials[k] == 0 || (trials[k] >= 16'h10 && trials[k] <= 16'h1000)) expv = trials[k];
            wbCycle(1, IPS_ADDR_TABLE_BASE, 32'(trials[k]));
            wbCycle(0, IPS_ADDR_TABLE_BASE, 0);
            checkVal("presetEntry1", rd, expv);
        end
        results();
    end
endmodule : input_polarity_multispeed_select_tb
